// ### verilog/cache_config_regs.sv
// cache geometry and extension configuration register pair
// assumes a word-wide register port on mclk_i with one-cycle strobes,
// and an outer cache controller that answers the bypass request
//
// What this block does
// - cache_config_two bit 31 reads one
// - bits 30:28 read zero, read-only
// - tertiary cache codes read zero: none exists
// - bits 15:13 read zero, read-only
// - writing bit 12 high raises bypass request
// - bit 12 reads acknowledge level, not written value
// - bit 12 reads zero until acknowledge arrives
// - secondary cache geometry preset in bits 11:0
// - extension_config is a read-only feature register
// - extension flags at their fixed bit places
// - decode: sets 64<<s, line 2<<l, ways a+1
// - extension_config continuation bit reads zero
// - interrupt controller flag follows its core input
`timescale 1ns/1ps
module cache_config_regs (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic bypass_request_out_o,
  input wire logic bypass_ack_in_i,
  input wire logic eic_present_i,
  output logic writable_cfg_enable_o,
  output logic l2_present_o,
  output logic [15:0] l2_sets_o,
  output logic [15:0] l2_line_bytes_o,
  output logic [4:0] l2_ways_o
);

  // the whole register state of the block
  typedef struct packed {
    logic [31:0] rdata; // read data, valid one cycle after a read
    logic bypass_req; // request level toward the outer cache
    logic wc_en; // lets software rewrite the geometry
    logic [3:0] l2_set; // secondary cache set code
    logic [3:0] l2_line; // secondary cache line code
    logic [3:0] l2_way; // secondary cache way code
    logic present; // decoded: a secondary cache exists
    logic [15:0] sets; // decoded sets per way
    logic [15:0] line_bytes; // decoded bytes per line
    logic [4:0] ways; // decoded way count
  } regs_type;

  regs_type cur; // registered state
  regs_type next_cur; // next state

  logic ack_level; // filtered acknowledge from the outer cache
  logic eic_level; // filtered controller-present strap
  logic [31:0] cc2_word; // assembled cache_config_two
  logic [31:0] ext_word; // assembled extension_config
  logic [31:0] ctrl_word; // assembled control word
  logic [31:0] geom_word; // decoded geometry readback
  logic [31:0] read_mux; // selected word for a read

  // sets per way from a set code
  function automatic logic [15:0] sets_of(input logic [3:0] code);
    logic [15:0] base;
    base = 16'(cfg_pkg::SETS_BASE);
    // codes above 9 overflow 16 bits; the top is simply dropped
    sets_of = base << code;
  endfunction : sets_of

  // bytes per line from a line code, zero meaning no cache
  function automatic logic [15:0] line_of(input logic [3:0] code);
    logic [15:0] base;
    base = 16'(cfg_pkg::LINE_BASE);
    if (code == 4'h0) begin
      line_of = 16'h0000;
    end else begin
      line_of = base << code;
    end
  endfunction : line_of

  // number of ways from a way code
  function automatic logic [4:0] ways_of(input logic [3:0] code);
    ways_of = {1'b0, code} + 5'h01;
  endfunction : ways_of

  // acknowledge from the outer cache arrives on its own timing
  pin_filter ack_filter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(bypass_ack_in_i),
    .level_o(ack_level)
  );

  // the strap is a system level, filtered the same way
  pin_filter eic_filter (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(eic_present_i),
    .level_o(eic_level)
  );

  // assemble cache_config_two from fixed and live fields
  always_comb begin
    cc2_word = 32'h0000_0000;
    // continuation: extension_config follows
    cc2_word[cfg_pkg::CC2_CONT_BIT] = cfg_pkg::CC2_CONT_VAL;
    // tertiary reserved bits are constant
    cc2_word[cfg_pkg::CC2_L3_RSV_LSB +: 3] = cfg_pkg::L3_RSV_VAL;
    // no tertiary cache, so all three codes are zero
    cc2_word[cfg_pkg::CC2_L3_SET_LSB +: 4] = cfg_pkg::L3_SET_VAL;
    cc2_word[cfg_pkg::CC2_L3_LINE_LSB +: 4] = cfg_pkg::L3_LINE_VAL;
    cc2_word[cfg_pkg::CC2_L3_WAY_LSB +: 4] = cfg_pkg::L3_WAY_VAL;
    // secondary reserved bits are constant
    cc2_word[cfg_pkg::CC2_L2_RSV_LSB +: 3] = cfg_pkg::L2_RSV_VAL;
    // bypass bit shows the acknowledge, never the written value;
    // so a fresh request reads zero until the outer cache answers
    cc2_word[cfg_pkg::CC2_BYPASS_BIT] = ack_level;
    // geometry codes as held
    cc2_word[cfg_pkg::CC2_L2_SET_LSB +: 4] = cur.l2_set;
    cc2_word[cfg_pkg::CC2_L2_LINE_LSB +: 4] = cur.l2_line;
    cc2_word[cfg_pkg::CC2_L2_WAY_LSB +: 4] = cur.l2_way;
  end

  // assemble extension_config; every bit is read-only
  always_comb begin
    ext_word = 32'h0000_0000; // 30:14, 12 and 8:7 stay zero
    // no further configuration register follows
    ext_word[cfg_pkg::EXT_CONT_BIT] = cfg_pkg::EXT_CONT_VAL;
    ext_word[cfg_pkg::EXT_USER_LOCAL_BIT] = cfg_pkg::USER_LOCAL_VAL;
    ext_word[cfg_pkg::EXT_SP_REV2_BIT] = cfg_pkg::SP_REV2_VAL;
    ext_word[cfg_pkg::EXT_SP_EXT_BIT] = cfg_pkg::SP_EXT_VAL;
    ext_word[cfg_pkg::EXT_CONTEXT_BIT] = cfg_pkg::CONTEXT_VAL;
    // follows the system strap, after filtering
    ext_word[cfg_pkg::EXT_IRQ_CTRL_BIT] = eic_level;
    ext_word[cfg_pkg::EXT_VECT_IRQ_BIT] = cfg_pkg::VECT_IRQ_VAL;
    ext_word[cfg_pkg::EXT_SMALL_PAGE_BIT] = cfg_pkg::SMALL_PAGE_VAL;
    ext_word[cfg_pkg::EXT_DEV_MAP_BIT] = cfg_pkg::DEV_MAP_VAL;
    ext_word[cfg_pkg::EXT_MTHREAD_BIT] = cfg_pkg::MTHREAD_VAL;
    ext_word[cfg_pkg::EXT_SECURE_BIT] = cfg_pkg::SECURE_VAL;
    ext_word[cfg_pkg::EXT_TRACE_BIT] = cfg_pkg::TRACE_VAL;
  end

  // control word: enable and the raw request level
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[cfg_pkg::CTRL_WC_BIT] = cur.wc_en;
    // lets software see a request still waiting for its answer
    ctrl_word[cfg_pkg::CTRL_REQ_BIT] = cur.bypass_req;
  end

  // decoded geometry readback: ways, line bytes, present flag
  always_comb begin
    geom_word = 32'h0000_0000;
    geom_word[15:0] = cur.line_bytes;
    geom_word[20:16] = cur.ways;
    geom_word[31] = cur.present;
  end

  // read select; unmapped offsets read as zero
  always_comb begin
    case (reg_addr_i)
      cfg_pkg::CACHE_CONFIG_TWO_OFS: begin
        read_mux = cc2_word;
      end
      cfg_pkg::EXTENSION_CONFIG_OFS: begin
        read_mux = ext_word;
      end
      cfg_pkg::CFG_CTRL_OFS: begin
        read_mux = ctrl_word;
      end
      cfg_pkg::L2_GEOMETRY_OFS: begin
        read_mux = geom_word;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  // next-state logic for every held bit
  always_comb begin
    next_cur = cur;
    // read data only stand in the cycle after the strobe
    if (reg_rd_i) begin
      next_cur.rdata = read_mux;
    end else begin
      next_cur.rdata = 32'h0000_0000;
    end
    // writes; read-only offsets simply drop the data
    if (reg_wr_i) begin
      case (reg_addr_i)
        cfg_pkg::CACHE_CONFIG_TWO_OFS: begin
          // the request holds whatever was last written, so a zero
          // withdraws it and the outer cache may leave bypass
          next_cur.bypass_req =
            reg_wdata_i[cfg_pkg::CC2_BYPASS_BIT];
          // geometry is fixed unless the enable is on
          if (cur.wc_en) begin
            next_cur.l2_set =
              reg_wdata_i[cfg_pkg::CC2_L2_SET_LSB +: 4];
            next_cur.l2_line =
              reg_wdata_i[cfg_pkg::CC2_L2_LINE_LSB +: 4];
            next_cur.l2_way =
              reg_wdata_i[cfg_pkg::CC2_L2_WAY_LSB +: 4];
          end
        end
        cfg_pkg::CFG_CTRL_OFS: begin
          next_cur.wc_en = reg_wdata_i[cfg_pkg::CTRL_WC_BIT];
        end
        default: begin
          // extension_config and unmapped offsets ignore writes
          next_cur.wc_en = cur.wc_en;
        end
      endcase
    end
    // decode held one cycle behind the codes; a trade of one
    // cycle of lag for short paths into the cache sizing logic
    next_cur.present = (cur.l2_line != 4'h0);
    next_cur.sets = sets_of(cur.l2_set);
    next_cur.line_bytes = line_of(cur.l2_line);
    next_cur.ways = ways_of(cur.l2_way);
  end

  // synchronous reset: request low, geometry preset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cur.rdata <= 32'h0000_0000;
      cur.bypass_req <= cfg_pkg::BYPASS_RST;
      cur.wc_en <= cfg_pkg::WC_RST;
      cur.l2_set <= cfg_pkg::L2_SET_RST;
      cur.l2_line <= cfg_pkg::L2_LINE_RST;
      cur.l2_way <= cfg_pkg::L2_WAY_RST;
      cur.present <= 1'b0;
      cur.sets <= 16'h0000;
      cur.line_bytes <= 16'h0000;
      cur.ways <= 5'h00;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_o = cur.rdata;
  // the outer cache obeys this level and answers on its pin
  assign bypass_request_out_o = cur.bypass_req;
  assign writable_cfg_enable_o = cur.wc_en;
  assign l2_present_o = cur.present;
  assign l2_sets_o = cur.sets;
  assign l2_line_bytes_o = cur.line_bytes;
  assign l2_ways_o = cur.ways;

endmodule : cache_config_regs

// ### verilog/cfg_pkg.sv
// constants for the cache and extension configuration register pair
// assumes a single 25 MHz core clock and a word-wide register port
package cfg_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // byte offsets of the registers on the plain register port
  localparam logic [7:0] CACHE_CONFIG_TWO_OFS = 8'h00;
  localparam logic [7:0] EXTENSION_CONFIG_OFS = 8'h04;
  localparam logic [7:0] CFG_CTRL_OFS = 8'h08;
  localparam logic [7:0] L2_GEOMETRY_OFS = 8'h0c;

  // cache_config_two field positions
  localparam int CC2_CONT_BIT = 31;
  localparam int CC2_L3_RSV_LSB = 28;
  localparam int CC2_L3_SET_LSB = 24;
  localparam int CC2_L3_LINE_LSB = 20;
  localparam int CC2_L3_WAY_LSB = 16;
  localparam int CC2_L2_RSV_LSB = 13;
  localparam int CC2_BYPASS_BIT = 12;
  localparam int CC2_L2_SET_LSB = 8;
  localparam int CC2_L2_LINE_LSB = 4;
  localparam int CC2_L2_WAY_LSB = 0;

  // fixed values of cache_config_two
  localparam logic CC2_CONT_VAL = 1'b1;
  localparam logic [2:0] L3_RSV_VAL = 3'h0;
  localparam logic [3:0] L3_SET_VAL = 4'h0;
  localparam logic [3:0] L3_LINE_VAL = 4'h0;
  localparam logic [3:0] L3_WAY_VAL = 4'h0;
  localparam logic [2:0] L2_RSV_VAL = 3'h0;

  // build-time secondary cache geometry, loaded at reset
  localparam logic [3:0] L2_SET_RST = 4'h2;
  localparam logic [3:0] L2_LINE_RST = 4'h4;
  localparam logic [3:0] L2_WAY_RST = 4'h7;
  localparam logic BYPASS_RST = 1'b0;
  localparam logic WC_RST = 1'b0;

  // extension_config field positions
  localparam int EXT_CONT_BIT = 31;
  localparam int EXT_USER_LOCAL_BIT = 13;
  localparam int EXT_SP_REV2_BIT = 11;
  localparam int EXT_SP_EXT_BIT = 10;
  localparam int EXT_CONTEXT_BIT = 9;
  localparam int EXT_IRQ_CTRL_BIT = 6;
  localparam int EXT_VECT_IRQ_BIT = 5;
  localparam int EXT_SMALL_PAGE_BIT = 4;
  localparam int EXT_DEV_MAP_BIT = 3;
  localparam int EXT_MTHREAD_BIT = 2;
  localparam int EXT_SECURE_BIT = 1;
  localparam int EXT_TRACE_BIT = 0;

  // fixed extension_config flag values
  localparam logic EXT_CONT_VAL = 1'b0;
  localparam logic USER_LOCAL_VAL = 1'b1;
  localparam logic SP_REV2_VAL = 1'b1;
  localparam logic SP_EXT_VAL = 1'b1;
  localparam logic CONTEXT_VAL = 1'b1;
  localparam logic VECT_IRQ_VAL = 1'b1;
  localparam logic SMALL_PAGE_VAL = 1'b0;
  localparam logic DEV_MAP_VAL = 1'b1;
  localparam logic MTHREAD_VAL = 1'b0;
  localparam logic SECURE_VAL = 1'b0;
  localparam logic TRACE_VAL = 1'b0;

  // control register bit positions
  localparam int CTRL_WC_BIT = 0;
  localparam int CTRL_REQ_BIT = 1;

  // geometry decode bases
  localparam int SETS_BASE = 64;
  localparam int LINE_BASE = 2;

  // pin filter depth and idle level
  localparam int SYNC_STAGES = 3;
  localparam logic SYNC_RST = 1'b0;

endpackage : cfg_pkg

// ### verilog/pin_filter.sv
// three-flop input filter for a level from outside the clock domain
// assumes the level is slow compared with the core clock
`timescale 1ns/1ps
module pin_filter (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);

  // all filter state in one word
  typedef struct packed {
    logic s1; // first stage, read only by the second
    logic s2; // second stage
    logic s3; // third stage
    logic lvl; // accepted level
  } filt_type;

  filt_type cur;
  filt_type next_cur;

  // accept a change only when stages two and three agree
  always_comb begin
    next_cur = cur;
    next_cur.s1 = pin_i;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    if (cur.s2 == cur.s3) begin
      next_cur.lvl = cur.s3;
    end
  end

  // synchronous reset to the idle level
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cur <= '{s1: cfg_pkg::SYNC_RST, s2: cfg_pkg::SYNC_RST,
               s3: cfg_pkg::SYNC_RST, lvl: cfg_pkg::SYNC_RST};
    end else begin
      cur <= next_cur;
    end
  end

  assign level_o = cur.lvl;

endmodule : pin_filter

// ### sim/l2_cache_model.sv
// outer cache model answering the bypass request after lag_i cycles
// assumes lag_i is held still while a request change is pending
`timescale 1ns/1ps
module l2_cache_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [3:0] lag_i,
  output logic ack_o
);
  logic [3:0] cnt; // cycles since the request moved
  // ack only follows once the bypass has had time to settle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt <= 4'h0;
      ack_o <= 1'b0;
    end else if (req_i == ack_o) begin
      cnt <= 4'h0;
    end else if (cnt < lag_i) begin
      cnt <= cnt + 4'h1;
    end else begin
      ack_o <= req_i;
    end
  end
endmodule : l2_cache_model

// ### sim/cfg_regs_asserts.sv
// checker bound to the configuration register pair
// assumes it sees only the top module ports, one clock domain
`timescale 1ns/1ps
module cfg_regs_checker (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic bypass_request_out_o,
  input wire logic bypass_ack_in_i,
  input wire logic eic_present_i,
  input wire logic writable_cfg_enable_o,
  input wire logic l2_present_o,
  input wire logic [15:0] l2_sets_o,
  input wire logic [15:0] l2_line_bytes_o,
  input wire logic [4:0] l2_ways_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic ack_q, eic_q;
  logic [2:0] quiet; // edges both pins held; filters need four
  // pin readback is only judged once the filters have settled
  always_ff @(posedge mclk_i) begin
    ack_q <= bypass_ack_in_i;
    eic_q <= eic_present_i;
    if (!rst_n_i || ack_q != bypass_ack_in_i || eic_q != eic_present_i)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end
  wire rd_cc2 = reg_rd_i && reg_addr_i == cfg_pkg::CACHE_CONFIG_TWO_OFS;
  wire rd_ext = reg_rd_i && reg_addr_i == cfg_pkg::EXTENSION_CONFIG_OFS;
  wire wr_cc2 = reg_wr_i && reg_addr_i == cfg_pkg::CACHE_CONFIG_TWO_OFS;
  wire wr_ctrl = reg_wr_i && reg_addr_i == cfg_pkg::CFG_CTRL_OFS;
  wire rd_geom = reg_rd_i && reg_addr_i == cfg_pkg::L2_GEOMETRY_OFS;
  rd_idle_zero_a: assert property (
    !reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data not zero outside a read answer");
  cc2_fixed_a: assert property (
    rd_cc2 |=> reg_rdata_o[31:13] == 19'h40000)
    else $error("fixed fields of cache_config_two wrong");
  ext_layout_a: assert property (
    rd_ext |=> (reg_rdata_o & 32'hffffffbf) == 32'h00002e28)
    else $error("extension_config layout wrong");
  // quiet still shows the old count at the edge where a pin moves,
  // so the pin must also be stable at the read edge itself
  ack_readback_a: assert property (
    rd_cc2 && quiet > 3'h5 && $stable(bypass_ack_in_i)
    |=> reg_rdata_o[12] == $past(bypass_ack_in_i))
    else $error("bypass bit does not show acknowledge");
  eic_follow_a: assert property (
    rd_ext && quiet > 3'h5 && $stable(eic_present_i)
    |=> reg_rdata_o[6] == $past(eic_present_i))
    else $error("interrupt controller flag does not follow pin");
  req_follow_a: assert property (
    wr_cc2 |=> bypass_request_out_o == $past(reg_wdata_i[12]))
    else $error("bypass request not written value");
  req_hold_a: assert property (
    !wr_cc2 |=> $stable(bypass_request_out_o))
    else $error("bypass request moved without a write");
  wc_follow_a: assert property (
    wr_ctrl |=> writable_cfg_enable_o == $past(reg_wdata_i[0]))
    else $error("geometry write enable not written value");
  geom_locked_a: assert property (
    wr_cc2 && !writable_cfg_enable_o |-> ##2 $stable(l2_ways_o) &&
    $stable(l2_sets_o) && $stable(l2_line_bytes_o))
    else $error("geometry changed while locked");
  geom_view_a: assert property (
    rd_geom && !$past(reg_wr_i) && !$past(reg_wr_i, 2) |=>
    reg_rdata_o == {$past(l2_present_o), 10'h0, $past(l2_ways_o),
    $past(l2_line_bytes_o)})
    else $error("decoded geometry view differs from outputs");
  req_cover: cover property ($rose(bypass_request_out_o));
  ack_cover: cover property (rd_cc2 && quiet > 3'h5 && bypass_ack_in_i);
  wc_cover: cover property (wr_cc2 && writable_cfg_enable_o);
endmodule : cfg_regs_checker

bind cache_config_regs cfg_regs_checker chk (.mclk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .bypass_request_out_o, .bypass_ack_in_i, .eic_present_i,
  .writable_cfg_enable_o, .l2_present_o, .l2_sets_o, .l2_line_bytes_o,
  .l2_ways_o);

// ### sim/test_cache_config_regs.sv
// self-checking bench for the configuration register pair
// assumes the outer cache model on the bypass pins and the bound checker
`timescale 1ns/1ps
module test_cache_config_regs;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic eic_present_i = 1'b0;
  logic [3:0] lag = 4'h0; // outer cache answer delay
  logic [31:0] reg_rdata_o;
  logic bypass_request_out_o, bypass_ack_in_i, writable_cfg_enable_o;
  logic l2_present_o;
  logic [15:0] l2_sets_o, l2_line_bytes_o;
  logic [4:0] l2_ways_o;
  logic [3:0] lags [2] = '{4'h0, 4'h9}; // prompt and slow answers
  logic [11:0] codes [4] = '{12'h135, 12'h300, 12'h9ef, 12'h247};
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  cache_config_regs dut (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bypass_request_out_o,
    .bypass_ack_in_i, .eic_present_i, .writable_cfg_enable_o,
    .l2_present_o, .l2_sets_o, .l2_line_bytes_o, .l2_ways_o);
  l2_cache_model far (.mclk_i, .rst_n_i, .req_i(bypass_request_out_o),
    .lag_i(lag), .ack_o(bypass_ack_in_i));

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : rd

  // decoded geometry worked out from the written codes
  task automatic geo_chk(input logic [11:0] c);
    logic [31:0] sets;
    logic [15:0] line;
    logic [4:0] ways;
    logic pres;
    sets = 32'd64 << c[11:8];
    line = (c[7:4] == 4'h0) ? 16'h0 : 16'(32'd2 << c[7:4]);
    ways = 5'(c[3:0]) + 5'h1;
    pres = c[7:4] != 4'h0;
    chk({l2_sets_o, l2_line_bytes_o}, {sets[15:0], line});
    chk({26'h0, l2_present_o, l2_ways_o}, {26'h0, pres, ways});
    rd(8'h0c, {pres, 10'h0, ways, line});
  endtask : geo_chk

  // hang guard: whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(8'h00, 32'h80000247);
    rd(8'h04, 32'h00002e28);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    geo_chk(12'h247);
    $display("reset values done");
    wr(8'h04, 32'hffffffff);
    rd(8'h04, 32'h00002e28);
    wr(8'h00, 32'h7fffefff);
    rd(8'h00, 32'h80000247);
    $display("read-only places done");
    foreach (lags[i]) begin
      @(posedge mclk_i);
      lag <= lags[i];
      wr(8'h00, 32'h00001000);
      #1 chk({31'h0, bypass_request_out_o}, 32'h1);
      rd(8'h00, 32'h80000247);
      rd(8'h08, 32'h2);
      repeat (24) @(posedge mclk_i);
      rd(8'h00, 32'h80001247);
      wr(8'h00, 32'h0);
      #1 chk({31'h0, bypass_request_out_o}, 32'h0);
      repeat (24) @(posedge mclk_i);
      rd(8'h00, 32'h80000247);
    end
    $display("bypass handshake done");
    wr(8'h08, 32'h1);
    #1 chk({31'h0, writable_cfg_enable_o}, 32'h1);
    rd(8'h08, 32'h1);
    foreach (codes[i]) begin
      wr(8'h00, {20'h0, codes[i]});
      rd(8'h00, {20'h80000, codes[i]});
      geo_chk(codes[i]);
    end
    wr(8'h08, 32'h0);
    #1 chk({31'h0, writable_cfg_enable_o}, 32'h0);
    wr(8'h00, 32'h00000135);
    rd(8'h00, 32'h80000247);
    $display("geometry writes done");
    @(posedge mclk_i);
    eic_present_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    rd(8'h04, 32'h00002e68);
    $display("strap done");
    wr(8'h00, 32'h00001000);
    @(posedge mclk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1 chk({31'h0, bypass_request_out_o}, 32'h0);
    rd(8'h00, 32'h80000247);
    $display("second reset done");
    tally_and_finish();
  end
endmodule : test_cache_config_regs
